// ---- rtl/bit_sync.sv ----
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // Reset to ones so an idle bus and a protected array are seen first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // bit_sync

`default_nettype wire

// ---- rtl/eeprom_pkg.sv ----
// Types shared by the serial EEPROM slave.
package eeprom_pkg;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_RX     = 7'h02,
    ST_ACK    = 7'h04,
    ST_TX     = 7'h08,
    ST_MACK   = 7'h10,
    ST_IGNORE = 7'h20,
    ST_SPARE  = 7'h40
  } bus_state_t;

  typedef enum logic [1:0] {
    ROLE_CTRL = 2'h0,
    ROLE_ADDR = 2'h1,
    ROLE_DATA = 2'h2
  } byte_role_t;

endpackage

// ---- rtl/eeprom_regs.svh ----
// Constants of the serial EEPROM slave: codes, sizes and timing counts.
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

`define DEVICE_CODE    4'ha
`define BYTE_BITS      4'h8
`define PAGE_LAST      4'hf
`define ADDR_ONE       8'h01
`define NIBBLE_ONE     4'h1
`define PROGRAM_PACE   2'h3
`define FIFO_WIDTH     16
`define FIFO_DEPTH     32
`define CLK_PERIOD_NS  50
`define WRITE_TIME_NS  5000000
`define WRITE_CYCLES   (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- rtl/eeprom_slave.sv ----
// Serial EEPROM slave: two-wire command logic, page buffer, array and self-timed write cycle.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"

// Functional notes
// - Page write buffers up to sixteen bytes.
// - Each data byte bumps pointer low nibble.
// - Over sixteen bytes wrap and overwrite buffer.
// - Stop after write starts programming cycle.
// - Protected writes acked, array unchanged, full busy.
// - Page overrun wraps to same page start.
// - Write-protect high protects whole array.
// - No acknowledge at all while busy.
// - Direction bit one selects read.
// - Pointer holds last accessed plus one, wrapped within the page after a write.
// - Read byte ends on master nack, release.
// - Address-only write loads pointer, no program.
// - After read pointer follows last byte.
// - Master ack gives next sequential byte.
// - Read pointer wraps top to zero.
// - Answer only matching code and chip select.
// - Byte after write control loads pointer.
module eeprom_slave #(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // Two-wire bus, open drain data
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Straps
  input  wire logic wp,
  input  wire logic chip_select_bit0,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit2,
  // Status
  output logic      write_busy
);
  import eeprom_pkg::*;

  logic [5:0]                   pins_s;
  logic                         scl_s;
  logic                         sda_s;
  logic                         wp_s;
  logic [2:0]                   cs_s;
  logic                         scl_d;
  logic                         sda_d;
  logic                         scl_rise;
  logic                         scl_fall;
  logic                         start_cond;
  logic                         stop_cond;

  bus_state_t                   state;
  byte_role_t                   role;
  logic [3:0]                   bit_cnt;
  logic [7:0]                   shift;
  logic [7:0]                   tx_sh;
  logic                         master_ack;
  logic [7:0]                   ptr;

  logic [7:0]                   mem [256];
  logic [7:0]                   mem_rd;
  logic [7:0]                   page_data [16];
  logic [15:0]                  page_valid;
  logic [3:0]                   page_base;
  logic                         write_pending;

  logic                         byte_done;
  logic                         tx_done;
  logic                         tx_load;
  logic                         ctrl_match;
  logic                         ctrl_accept;
  logic                         write_accept;

  logic [31:0]                  busy_cnt;
  logic                         walking;
  logic [3:0]                   walk_idx;
  logic                         walk_step;
  logic [1:0]                   pace;

  logic                         fifo_in_valid;
  logic                         fifo_in_ready;
  logic [`FIFO_WIDTH-1:0]       fifo_in_data;
  logic                         fifo_out_valid;
  logic                         fifo_out_ready;
  logic [`FIFO_WIDTH-1:0]       fifo_out_data;

  // Every pin crosses into the clock domain before any logic looks at it.
  bit_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .clk  (ref_clk),
    .rstn (rstn),
    .din  ({scl, sda_in, wp, chip_select_bit2, chip_select_bit1, chip_select_bit0}),
    .dout (pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign wp_s  = pins_s[3];
  assign cs_s  = pins_s[2:0];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise   = scl_s && !scl_d;
  assign scl_fall   = !scl_s && scl_d;
  assign start_cond = scl_s && scl_d && sda_d && !sda_s;
  assign stop_cond  = scl_s && scl_d && !sda_d && sda_s;

  assign byte_done    = (state == ST_RX) && scl_fall && (bit_cnt == `BYTE_BITS);
  assign tx_done      = (state == ST_TX) && scl_fall && (bit_cnt == `BYTE_BITS);
  assign tx_load      = scl_fall && ((state == ST_ACK && role == ROLE_CTRL && shift[0]) ||
                                     (state == ST_MACK && master_ack));
  assign ctrl_match   = (shift[7:4] == `DEVICE_CODE) && (shift[3:1] == cs_s);
  assign ctrl_accept  = byte_done && (role == ROLE_CTRL) && ctrl_match && !write_busy;
  assign write_accept = ctrl_accept && !shift[0];
  assign mem_rd       = mem[ptr];

  // Bus sequencing: bytes in, acknowledge, bytes out, master acknowledge.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state      <= ST_IDLE;
      role       <= ROLE_CTRL;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      sda_oe     <= 1'b0;
    end else if (start_cond) begin
      state   <= ST_RX;
      role    <= ROLE_CTRL;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (stop_cond) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_IDLE, ST_IGNORE, ST_SPARE: begin
          sda_oe <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            if (role != ROLE_CTRL || ctrl_accept) begin
              state  <= ST_ACK;
              sda_oe <= 1'b1;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (role == ROLE_CTRL && shift[0]) begin
              state  <= ST_TX;
              sda_oe <= !mem_rd[7];
            end else begin
              state  <= ST_RX;
              sda_oe <= 1'b0;
              role   <= (role == ROLE_CTRL) ? ROLE_ADDR : ROLE_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (tx_done) begin
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
            state   <= ST_MACK;
          end else if (scl_fall) begin
            sda_oe <= !tx_sh[7];
          end
        end
        ST_MACK: begin
          if (scl_fall) begin
            if (master_ack) begin
              state  <= ST_TX;
              sda_oe <= !mem_rd[7];
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Master acknowledge, taken at the ninth rise of each byte the slave sends.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      master_ack <= 1'b0;
    end else if (state == ST_MACK && scl_rise) begin
      master_ack <= !sda_s;
    end
  end

  // Transmit shifter. The top bit goes straight to the line, so only seven bits are kept.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh <= 8'h00;
    end else if (tx_load) begin
      tx_sh <= {mem_rd[6:0], 1'b0};
    end else if (state == ST_TX && scl_fall && !tx_done) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // Open drain: the pin is only ever pulled low.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Address pointer.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= 8'h00;
    end else if (byte_done && role == ROLE_ADDR) begin
      ptr <= shift;
    end else if (byte_done && role == ROLE_DATA) begin
      ptr <= {ptr[7:4], ptr[3:0] + `NIBBLE_ONE};
    end else if (tx_done) begin
      ptr <= ptr + `ADDR_ONE;
    end
  end

  // Page buffer; a byte landing on a used slot replaces the older one.
  always_ff @(posedge ref_clk) begin
    if (byte_done && role == ROLE_DATA) begin
      page_data[ptr[3:0]] <= shift;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      page_valid    <= 16'h0000;
      page_base     <= 4'h0;
      write_pending <= 1'b0;
    end else if (write_accept) begin
      page_valid    <= 16'h0000;
      write_pending <= 1'b0;
    end else if (byte_done && role == ROLE_DATA) begin
      page_valid[ptr[3:0]] <= 1'b1;
      page_base            <= ptr[7:4];
      write_pending        <= 1'b1;
    end else if (stop_cond || start_cond) begin
      write_pending <= 1'b0;
    end
  end

  // Self-timed write cycle. The buffer is handed to the array through the
  // FIFO a slot at a time, so the busy time never depends on the byte count.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      write_busy <= 1'b0;
      busy_cnt   <= 32'h0000_0000;
      walking    <= 1'b0;
      walk_idx   <= 4'h0;
    end else if (stop_cond && write_pending) begin
      write_busy <= 1'b1;
      busy_cnt   <= 32'h0000_0000;
      walking    <= !wp_s;
      walk_idx   <= 4'h0;
    end else begin
      if (write_busy) begin
        if (busy_cnt >= WRITE_CYCLES - 1 && !walking && !fifo_out_valid) begin
          write_busy <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt + 32'h0000_0001;
        end
      end
      if (walk_step) begin
        walk_idx <= walk_idx + 4'h1;
        if (walk_idx == `PAGE_LAST) begin
          walking <= 1'b0;
        end
      end
    end
  end

  assign walk_step     = walking && (!page_valid[walk_idx] || fifo_in_ready);
  assign fifo_in_valid = walking && page_valid[walk_idx];
  assign fifo_in_data  = {page_base, walk_idx, page_data[walk_idx]};

  sync_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_prog_fifo (
    .clk       (ref_clk),
    .rstn      (rstn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // The array takes one byte every few clocks, which is what lets the FIFO back up.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pace <= 2'h0;
    end else begin
      pace <= pace + 2'h1;
    end
  end

  assign fifo_out_ready = (pace == `PROGRAM_PACE);

  always_ff @(posedge ref_clk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      mem[fifo_out_data[15:8]] <= fifo_out_data[7:0];
    end
  end

endmodule // eeprom_slave

`default_nettype wire

// ---- rtl/sync_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none

module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = store[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // sync_fifo

`default_nettype wire

// ---- verification/bus_master.sv ----
// Two-wire bus master that clocks the slave and moves bytes.
`timescale 1ns/10ps
`default_nettype none
module bus_master (
  // Clock
  input  wire logic ref_clk,
  // Bus
  input  wire logic sda,
  output logic      scl,
  output logic      oe
);
  initial begin
    scl = 1'b1;
    oe = 1'b0;
  end
  // Lines move only just after a clock edge; SCL idles high between frames.
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic start();
    scl = 1'b0;
    w(2);
    oe = 1'b0;
    w(3);
    scl = 1'b1;
    w(2);
    oe = 1'b1;
    w(2);
  endtask
  task automatic stop();
    scl = 1'b0;
    w(2);
    oe = 1'b1;
    w(3);
    scl = 1'b1;
    w(2);
    oe = 1'b0;
    w(4);
  endtask
  // Sampling one clock after the rise leaves the slave its full reaction time.
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    w(2);
    oe = !b;
    w(3);
    scl = 1'b1;
    w(1);
    r = sda;
    w(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(!mack, r);
  endtask
endmodule  // bus_master
`default_nettype wire

// ---- verification/eeprom_slave_props.sv ----
// Bus and write-cycle checks of the serial EEPROM slave.
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_regs.svh"
module eeprom_slave_props #(
  parameter int unsigned WRITE_CYCLES = 200
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Bus
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Straps and status
  input wire logic wp,
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit2,
  input wire logic write_busy
);
  logic        scl_q;
  logic        sda_q;
  logic        first;
  logic        rd;
  logic [3:0]  bits;
  logic [3:0]  since_stop;
  logic [7:0]  sh;
  int unsigned busy_cnt;
  wire         rise  = scl && !scl_q;
  wire         stop  = scl && scl_q && !sda_q && sda_in;
  wire         start = scl && scl_q && sda_q && !sda_in;
  wire         match = sh[7:4] == `DEVICE_CODE && sh[3:1] == {chip_select_bit2, chip_select_bit1, chip_select_bit0};
  // The pins are watched directly, so bit counts lead the slave's own view by its synchroniser delay.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      rd <= 1'b0;
      bits <= 4'h0;
      since_stop <= 4'hf;
      sh <= 8'h00;
      busy_cnt <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      since_stop <= stop ? 4'h0 : since_stop + {3'h0, since_stop != 4'hf};
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
      if (start) begin
        bits <= 4'h0;
        first <= 1'b1;
      end else if (rise) begin
        sh <= {sh[6:0], sda_in};
        bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
        if (bits == 4'h8) begin
          first <= 1'b0;
          rd <= first ? sh[0] : rd;
        end
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence ctrl_end;
    rise && first && bits == 4'h8;
  endsequence
  ctrl_nack_a: assert property (ctrl_end and !match |-> !sda_oe)
    else $error("foreign control byte acknowledged");
  ctrl_ack_a: assert property (ctrl_end and match && !$past(write_busy, 8) |-> sda_oe)
    else $error("matching control byte not acknowledged");
  ctrl_quiet_a: assert property (rise && first && bits < 4'h8 |-> !sda_oe)
    else $error("slave drives during control byte");
  busy_quiet_a: assert property (write_busy |-> !sda_oe)
    else $error("slave drives while busy");
  busy_start_a: assert property ($rose(write_busy) |-> since_stop < 4'h8 && !rd)
    else $error("write cycle started without a write stop");
  busy_len_a: assert property ($fell(write_busy) |-> busy_cnt >= WRITE_CYCLES - 2 && busy_cnt <= WRITE_CYCLES + 100)
    else $error("write cycle length wrong");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("data line changed while clock high");
  out_low_a: assert property (sda_oe |-> !sda_out)
    else $error("open drain output not low");
endmodule  // eeprom_slave_props
`default_nettype wire

// ---- verification/serial_eeprom_page_write_read_tb.sv ----
// Self-checking bench of the serial EEPROM slave.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %s expected %h got %h", what, exp, got); end end
module serial_eeprom_page_write_read_tb;
  localparam int unsigned WCYC = 200;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic       scl;
  logic       m_oe;
  logic       sda_out;
  logic       sda_oe;
  logic       write_busy;
  wire        sda = !(sda_oe || m_oe);
  logic [7:0] mem [256];
  logic [7:0] ptr;
  logic [7:0] seed = 8'h47;
  logic       pend = 1'b0;
  int         num_errors = 0;
  int         n_checks = 0;
  int         cycles = 0;
  always #25 ref_clk = ~ref_clk;
  eeprom_slave #(.WRITE_CYCLES(WCYC)) u_eeprom_slave (.ref_clk, .rstn, .scl, .sda_in(sda), .sda_out, .sda_oe,
    .wp, .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]), .write_busy);
  bus_master u_bus_master (.ref_clk, .sda, .scl, .oe(m_oe));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] page_next(input logic [7:0] a);
    return {a[7:4], a[3:0] + 4'h1};
  endfunction
  task automatic finish_test();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic ctrl_poll();
    logic ack;
    int   tries;
    ack = 1'b0;
    tries = 0;
    while (!ack && tries < 20) begin
      u_bus_master.start();
      u_bus_master.wbyte({4'ha, cs, 1'b0}, ack);
      tries++;
    end
    `CHECK("poll ack", 1'b1, ack)
    if (pend) `CHECK("nack while busy", 1'b1, tries > 1)
    pend = 1'b0;
  endtask
  task automatic page_write(input logic [7:0] a, input int n, input logic prot);
    logic ack;
    wp = prot;
    ctrl_poll();
    u_bus_master.wbyte(a, ack);
    ptr = a;
    repeat (n) begin
      seed = lfsr(seed);
      u_bus_master.wbyte(seed, ack);
      `CHECK("data ack", 1'b1, ack)
      if (!prot) mem[ptr] = seed;
      ptr = page_next(ptr);
    end
    u_bus_master.stop();
    repeat (8) @(posedge ref_clk);
    #1;
    `CHECK("busy after stop", n > 0, write_busy)
    pend = n > 0;
  endtask
  task automatic read_seq(input logic rnd, input logic [7:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    ctrl_poll();
    if (rnd) begin
      u_bus_master.wbyte(a, ack);
      ptr = a;
    end
    u_bus_master.start();
    u_bus_master.wbyte({4'ha, cs, 1'b1}, ack);
    `CHECK("read ctrl ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      u_bus_master.rbyte(i < n - 1, d);
      `CHECK("read data", mem[ptr], d)
      ptr++;
    end
    u_bus_master.stop();
  endtask
  task automatic bad_ctrl(input logic [7:0] c);
    logic ack;
    u_bus_master.start();
    u_bus_master.wbyte(c, ack);
    `CHECK("foreign ctrl ack", 1'b0, ack)
    u_bus_master.wbyte(8'h00, ack);
    `CHECK("ignored byte ack", 1'b0, ack)
    u_bus_master.stop();
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    seed = lfsr(seed);
    cs = seed[2:0];
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    page_write(8'hf8, 20, 1'b0);
    page_write(8'h00, 16, 1'b0);
    read_seq(1'b0, 8'h00, 1);
    read_seq(1'b1, 8'hf0, 32);
    read_seq(1'b1, 8'hff, 1);
    read_seq(1'b0, 8'h00, 2);
    page_write(8'h04, 4, 1'b1);
    read_seq(1'b1, 8'h04, 4);
    page_write(8'h0a, 0, 1'b0);
    read_seq(1'b0, 8'h00, 1);
    bad_ctrl({4'ha, ~cs, 1'b0});
    bad_ctrl({4'h5, cs, 1'b0});
    read_seq(1'b0, 8'h00, 1);
    finish_test();
  end
endmodule  // serial_eeprom_page_write_read_tb
bind eeprom_slave eeprom_slave_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.ref_clk, .rstn, .scl, .sda_in,
  .sda_out, .sda_oe, .wp, .chip_select_bit0, .chip_select_bit1, .chip_select_bit2, .write_busy);
`default_nettype wire
